// ==== rtl/imap_defines.svh ====
// constants: frame offsets, access-size codes, register offsets and reset values
`ifndef IMAP_DEFINES_SVH
`define IMAP_DEFINES_SVH
// ==========================================================
// frame select (addr[15:12])
`define IMAP_FR_CPU 4'h0
`define IMAP_FR_VCPU 4'h1
`define IMAP_FR_HYP 4'h2
`define IMAP_FR_DIST 4'h3
`define IMAP_FR_REDIST 4'h4
`define IMAP_FR_XLAT 4'h5
// ==========================================================
// access size codes (log2 bytes)
`define IMAP_SZ_B 3'h0
`define IMAP_SZ_H 3'h1
`define IMAP_SZ_W 3'h2
`define IMAP_SZ_D 3'h3
// ==========================================================
// register offsets inside a frame (addr[11:0])
`define IMAP_OFS_PMR 12'h004
`define IMAP_OFS_CTLR 12'h000
`define IMAP_OFS_ACK 12'h00C
`define IMAP_OFS_DEACT 12'h010
`define IMAP_OFS_ROID 12'h018
`define IMAP_OFS_WOREG 12'h01C
`define IMAP_OFS_BASE64 12'h030
`define IMAP_OFS_FULL64 12'h038
`define IMAP_OFS_DOORBELL 12'h040
`define IMAP_OFS_SETNS 12'h044
`define IMAP_OFS_CLRNS 12'h048
`define IMAP_OFS_SETS 12'h04C
`define IMAP_OFS_CLRS 12'h050
`define IMAP_OFS_PRIO_LO 12'h400
`define IMAP_OFS_PRIO_HI 12'h41F
`define IMAP_OFS_TGT_LO 12'h800
`define IMAP_OFS_TGT_HI 12'h81F
`define IMAP_OFS_SGIP_LO 12'hF10
`define IMAP_OFS_SGIP_HI 12'hF2F
// ==========================================================
// reset values
`define IMAP_RST_PMR 8'h00
`define IMAP_RST_ROID 32'h0000_0A5A
`define IMAP_NO_IRQ 10'h3FF
`endif

// ==== rtl/imap_pkg.sv ====
// types shared by both ends of the register access port
package imap_pkg;
  typedef enum logic [1:0] {
    IMAP_IDLE = 2'b00,
    IMAP_REQ = 2'b01,
    IMAP_WAIT = 2'b10
  } imap_hst_state_t;
  typedef struct packed {
    logic ok;
    logic [63:0] data;
  } imap_rsp_t;
endpackage : imap_pkg

// ==== rtl/imap_if.sv ====
// link between requester and register access port
`timescale 1ns/100ps
interface imap_if;
  logic req;
  logic wr;
  logic [15:0] addr;
  logic [2:0] size;
  logic excl;
  logic [63:0] wdata;
  logic ack;
  logic err;
  logic [63:0] rdata;
  modport dev (input req, wr, addr, size, excl, wdata, output ack, err, rdata);
  modport hst (output req, wr, addr, size, excl, wdata, input ack, err, rdata);
endinterface : imap_if

// ==== rtl/imap_legal.sv ====
// access legality check: size, alignment and register class
`timescale 1ns/100ps
`include "imap_defines.svh"
module imap_legal
  import imap_pkg::*;
(
  // access
  input wire logic [15:0] addr_i,
  input wire logic [2:0] size_i,
  input wire logic excl_i,
  // result
  output logic legal_o
);
  wire [3:0] frame = addr_i[15:12];
  wire [11:0] ofs = addr_i[11:0];
  wire frame_ok = frame <= `IMAP_FR_XLAT;
  wire wide_frame = (frame == `IMAP_FR_DIST) || (frame == `IMAP_FR_REDIST) ||
                    (frame == `IMAP_FR_XLAT);
  wire is_byte_reg = (frame == `IMAP_FR_DIST) &&
    ((ofs >= `IMAP_OFS_PRIO_LO && ofs <= `IMAP_OFS_PRIO_HI) ||
     (ofs >= `IMAP_OFS_TGT_LO && ofs <= `IMAP_OFS_TGT_HI) ||
     (ofs >= `IMAP_OFS_SGIP_LO && ofs <= `IMAP_OFS_SGIP_HI));
  wire is_msg_reg = ((frame == `IMAP_FR_XLAT) && ofs == `IMAP_OFS_DOORBELL) ||
    ((frame == `IMAP_FR_DIST) && (ofs == `IMAP_OFS_SETNS || ofs == `IMAP_OFS_CLRNS ||
     ofs == `IMAP_OFS_SETS || ofs == `IMAP_OFS_CLRS));
  wire is_64 = wide_frame && (ofs[11:3] == `IMAP_OFS_BASE64 >> 3 ||
                              ofs[11:3] == `IMAP_OFS_FULL64 >> 3);
  wire is_full64 = wide_frame && ofs[11:3] == `IMAP_OFS_FULL64 >> 3;
  wire aligned = (size_i == `IMAP_SZ_B) || (size_i == `IMAP_SZ_H && !addr_i[0]) ||
                 (size_i == `IMAP_SZ_W && addr_i[1:0] == 2'b00) ||
                 (size_i == `IMAP_SZ_D && addr_i[2:0] == 3'b000);
  wire ok_w = (size_i == `IMAP_SZ_W) && !is_full64;
  wire ok_d = (size_i == `IMAP_SZ_D) && is_64;
  wire ok_b = (size_i == `IMAP_SZ_B) && is_byte_reg;
  wire ok_h = (size_i == `IMAP_SZ_H) && is_msg_reg;
  assign legal_o = frame_ok && aligned && !excl_i && (ok_w || ok_d || ok_b || ok_h);
endmodule : imap_legal

// ==== rtl/imap_dev.sv ====
// device end: memory-mapped register access port of the interrupt controller
`timescale 1ns/100ps
`include "imap_defines.svh"
// Function
// - 32-bit access to all frames accepted
// - 64-bit register halves accessible separately; the full-width register here takes only 64-bit accesses
// - atomic 64-bit access to 64-bit registers
// - byte access only to listed arrays
// - message registers take 16/32-bit accesses
// - little-endian byte lanes
// - unaligned accesses are unsupported
// - wrong-size, wide and exclusive accesses unsupported
// - unsupported access outcome is implementation choice
// - accesses complete in arrival order
// - requester issues single-register device accesses
// - read-only ignores writes, write-only reads undefined
// - both views share mask, active priority, binary point
// - sharing mode change makes contents undefined
// - same priority bits and minimum binary point
// - frames may read zero, ignore writes
// - virtual frame kept when enable programmable; here the virtual frame also reads zero and ignores writes while sysreg enabled
// - forbidden accesses may be reported
// - priority mask write effective at once
// - acknowledge read reflected in request lines
// - mask, group enables observed after barrier
// - acknowledge and deactivate visible after barrier
module imap_dev
  import imap_pkg::*;
#(
  parameter int PRIO_BITS = 8,
  parameter int NUM_IRQ = 32
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // bus side
  imap_if.dev bus,
  // system-register view and configuration
  input wire logic sysreg_enable_bit_i,
  input wire logic sysreg_pmr_we_i,
  input wire logic [7:0] sysreg_pmr_wdata_i,
  input wire logic [NUM_IRQ-1:0] irq_pending_i,
  // core side
  output logic [7:0] priority_mask_o,
  output logic group0_enable_o,
  output logic group1_enable_o,
  output logic irq_req_o,
  output logic [9:0] last_ack_id_o,
  output logic [9:0] last_deact_id_o,
  output logic forbidden_o
);
  logic [63:0] base64_ff;
  logic [63:0] full64_ff;
  logic [7:0] prio_ff [NUM_IRQ];
  logic [7:0] tgt_ff [NUM_IRQ];
  logic [NUM_IRQ-1:0] active_ff;
  logic [NUM_IRQ-1:0] sgi_pend_ff;
  logic [NUM_IRQ-1:0] msg_pend_ff;
  logic [7:0] pmr_ff;
  logic g0_ff;
  logic g1_ff;
  logic ack_ff;
  logic err_ff;
  logic [63:0] rdata_ff;
  logic [9:0] ack_id_ff;
  logic [9:0] deact_id_ff;
  logic irq_ff;
  logic forb_ff;
  logic share_ff;
  logic legal;
  // ==========================================================
  // decode
  wire [3:0] frame = bus.addr[15:12];
  wire [11:0] ofs = bus.addr[11:0];
  wire start = bus.req && !ack_ff;
  wire is_cpu = frame == `IMAP_FR_CPU;
  wire is_vcpu = frame == `IMAP_FR_VCPU;
  wire is_hyp = frame == `IMAP_FR_HYP;
  // cpu frames read zero and ignore writes while sysreg enabled
  wire read_zero_write_ignore = sysreg_enable_bit_i && (is_cpu || is_hyp || is_vcpu);
  wire ok = start && legal && !read_zero_write_ignore;
  wire wr_ok = ok && bus.wr;
  wire [4:0] idx = {1'b0, ofs[3:0]};
  wire [2:0] lane = bus.addr[2:0];
  wire in_prio = ofs >= `IMAP_OFS_PRIO_LO && ofs <= `IMAP_OFS_PRIO_HI;
  wire in_tgt = ofs >= `IMAP_OFS_TGT_LO && ofs <= `IMAP_OFS_TGT_HI;
  wire in_sgip = ofs >= `IMAP_OFS_SGIP_LO && ofs <= `IMAP_OFS_SGIP_HI;
  wire is_dist = frame == `IMAP_FR_DIST;
  wire wr_prio = wr_ok && is_dist && in_prio;
  wire wr_tgt = wr_ok && is_dist && in_tgt;
  wire is_w64 = frame == `IMAP_FR_DIST || frame == `IMAP_FR_REDIST ||
                frame == `IMAP_FR_XLAT;
  wire hit_pmr = is_cpu && ofs == `IMAP_OFS_PMR;
  wire hit_ctlr = is_cpu && ofs == `IMAP_OFS_CTLR;
  wire hit_ack = is_cpu && ofs == `IMAP_OFS_ACK;
  wire hit_deact = is_cpu && ofs == `IMAP_OFS_DEACT;
  wire hit_b64 = is_w64 && ofs[11:3] == `IMAP_OFS_BASE64 >> 3;
  wire hit_f64 = is_w64 && ofs[11:3] == `IMAP_OFS_FULL64 >> 3;
  wire hit_msg = is_dist && (ofs == `IMAP_OFS_SETNS || ofs == `IMAP_OFS_SETS);
  wire hit_clr = is_dist && (ofs == `IMAP_OFS_CLRNS || ofs == `IMAP_OFS_CLRS);
  // ==========================================================
  // highest-priority pending interrupt above mask
  logic [9:0] best_id;
  logic [7:0] best_pri;
  logic best_ok;
  always_comb begin
    best_id = `IMAP_NO_IRQ;
    best_pri = 8'hFF;
    best_ok = 1'b0;
    for (int i = 0; i < NUM_IRQ; i++) begin
      if ((irq_pending_i[i] || sgi_pend_ff[i] || msg_pend_ff[i]) && !active_ff[i] &&
          prio_ff[i] < pmr_ff && prio_ff[i] < best_pri) begin
        best_pri = prio_ff[i];
        best_id = 10'(i);
        best_ok = 1'b1;
      end
    end
  end
  // acknowledge read activates the interrupt in the same cycle
  wire ack_take = ok && !bus.wr && hit_ack && best_ok;
  // byte lane of the data bus is addr[2:0], little endian
  wire [7:0] wbyte = bus.wdata[8*lane +: 8];
  wire [31:0] wword = bus.addr[2] ? bus.wdata[63:32] : bus.wdata[31:0];
  wire [7:0] lanes = (bus.size == `IMAP_SZ_B) ? 8'h01 << lane :
                     (bus.size == `IMAP_SZ_H) ? 8'h03 << lane :
                     (bus.size == `IMAP_SZ_W) ? 8'h0F << lane : 8'hFF;
  wire [NUM_IRQ-1:0] id_bit = NUM_IRQ'(1) << wword[4:0];
  wire [NUM_IRQ-1:0] deact_bit = NUM_IRQ'(1) << wword[4:0];
  // ==========================================================
  // read mux, write-only registers read zero
  logic [31:0] rword;
  logic [63:0] rmux;
  always_comb begin
    rword = 32'h0000_0000;
    if (hit_pmr) rword[7:0] = pmr_ff;
    else if (hit_ctlr) rword[1:0] = {g1_ff, g0_ff};
    else if (hit_ack) rword[9:0] = best_id;
    else if (is_cpu && ofs == `IMAP_OFS_ROID) rword = `IMAP_RST_ROID;
    rmux = bus.addr[2] ? {rword, 32'h0000_0000} : {32'h0000_0000, rword};
    if (hit_b64) rmux = base64_ff;
    else if (hit_f64) rmux = full64_ff;
    else if (is_dist && in_sgip) rmux[8*lane +: 8] = {7'h00, sgi_pend_ff[idx]};
    for (int k = 0; k < 8; k++) begin
      if (is_dist && in_prio && lanes[k]) rmux[8*k +: 8] = prio_ff[{ofs[4:3], 3'(k)}];
      if (is_dist && in_tgt && lanes[k]) rmux[8*k +: 8] = tgt_ff[{ofs[4:3], 3'(k)}];
    end
    // a word access to a 64-bit register sees only its own lanes
    if ((hit_b64 || hit_f64) && bus.size == `IMAP_SZ_W) begin
      rmux = rmux & (bus.addr[2] ? 64'hFFFF_FFFF_0000_0000 : 64'h0000_0000_FFFF_FFFF);
    end
  end
  // ==========================================================
  // state
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pmr_ff <= `IMAP_RST_PMR;
      g0_ff <= 1'b0;
      g1_ff <= 1'b0;
      base64_ff <= 64'h0000_0000_0000_0000;
      full64_ff <= 64'h0000_0000_0000_0000;
      active_ff <= '0;
      sgi_pend_ff <= '0;
      msg_pend_ff <= '0;
      ack_id_ff <= `IMAP_NO_IRQ;
      deact_id_ff <= `IMAP_NO_IRQ;
      share_ff <= 1'b0;
      for (int i = 0; i < NUM_IRQ; i++) begin
        prio_ff[i] <= 8'h00;
        tgt_ff[i] <= 8'h00;
      end
    end else begin
      share_ff <= sysreg_enable_bit_i;
      // contents undefined on sharing change, only the priority mask cleared here
      if (share_ff != sysreg_enable_bit_i) begin
        pmr_ff <= `IMAP_RST_PMR;
      // one shared mask, system view write effective next edge
      end else if (sysreg_pmr_we_i) begin
        pmr_ff <= sysreg_pmr_wdata_i & ~8'(8'hFF >> PRIO_BITS);
      end else if (wr_ok && hit_pmr) begin
        // same implemented priority bits in both views
        pmr_ff <= wword[7:0] & ~8'(8'hFF >> PRIO_BITS);
      end
      // group enables registered once the write completes
      if (wr_ok && hit_ctlr) begin
        g0_ff <= wword[0];
        g1_ff <= wword[1];
      end
      if (wr_ok && hit_b64 && bus.size == `IMAP_SZ_D) base64_ff <= bus.wdata;
      else if (wr_ok && hit_b64 && bus.addr[2]) base64_ff[63:32] <= bus.wdata[63:32];
      else if (wr_ok && hit_b64) base64_ff[31:0] <= bus.wdata[31:0];
      if (wr_ok && hit_f64) full64_ff <= bus.wdata;
      // byte arrays, one element per enabled lane
      for (int k = 0; k < 8; k++) begin
        if (wr_prio && lanes[k]) prio_ff[{ofs[4:3], 3'(k)}] <= bus.wdata[8*k +: 8];
        if (wr_tgt && lanes[k]) tgt_ff[{ofs[4:3], 3'(k)}] <= bus.wdata[8*k +: 8];
      end
      if (wr_ok && is_dist && in_sgip && wbyte != 8'h00) begin
        sgi_pend_ff[idx] <= ofs < `IMAP_OFS_SGIP_LO + 12'h010;
      end
      // distributor message registers set or clear pending state, doorbell writes change nothing
      if (wr_ok && hit_msg) msg_pend_ff <= msg_pend_ff | id_bit;
      if (wr_ok && hit_clr) msg_pend_ff <= msg_pend_ff & ~id_bit;
      // acknowledge and deactivate recorded on completion
      if (ack_take) begin
        active_ff[best_id[4:0]] <= 1'b1;
        ack_id_ff <= best_id;
      end else if (wr_ok && hit_deact) begin
        active_ff <= active_ff & ~deact_bit;
        deact_id_ff <= {5'h00, wword[4:0]};
      end
    end
  end
  // ==========================================================
  // response: one access at a time, answered in order
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_ff <= 1'b0;
      err_ff <= 1'b0;
      rdata_ff <= 64'h0000_0000_0000_0000;
      forb_ff <= 1'b0;
    end else begin
      ack_ff <= start;
      // error, read zero, no state change
      err_ff <= start && !legal;
      rdata_ff <= (ok && !bus.wr) ? rmux : 64'h0000_0000_0000_0000;
      // forbidden frame access flagged for one cycle
      forb_ff <= start && read_zero_write_ignore;
    end
  end
  // request line follows mask and activation
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) irq_ff <= 1'b0;
    else irq_ff <= best_ok && !ack_take && (g0_ff || g1_ff);
  end
  imap_legal imap_legal_inst (
    .addr_i(bus.addr),
    .size_i(bus.size),
    .excl_i(bus.excl),
    .legal_o(legal)
  );
  assign bus.ack = ack_ff;
  assign bus.err = err_ff;
  assign bus.rdata = rdata_ff;
  assign priority_mask_o = pmr_ff;
  assign group0_enable_o = g0_ff;
  assign group1_enable_o = g1_ff;
  assign irq_req_o = irq_ff;
  assign last_ack_id_o = ack_id_ff;
  assign last_deact_id_o = deact_id_ff;
  assign forbidden_o = forb_ff;
endmodule : imap_dev

// ==== rtl/imap_hst.sv ====
// requester end: Avalon-MM slave for software, issues single accesses on the link
`timescale 1ns/100ps
`include "imap_defines.svh"
module imap_hst
  import imap_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // link
  imap_if.hst link
);
  // command regs: 0 addr, 1 {excl,size}, 2 wdata lo, 3 wdata hi, 4 go,
  // 5 status {err,busy}, 6 rdata lo, 7 rdata hi
  imap_hst_state_t state_ff;
  logic [15:0] addr_ff;
  logic [2:0] size_ff;
  logic excl_ff;
  logic wr_ff;
  logic [63:0] wdata_ff;
  logic [63:0] rdata_ff;
  logic err_ff;
  logic [31:0] avs_rd_ff;
  logic avs_ack_ff;
  wire avs_req = (avs_read || avs_write) && !avs_ack_ff;
  // writes land at the edge where the master sees waitrequest low
  wire avs_wr = avs_write && avs_ack_ff;
  wire go = avs_wr && avs_address == 4'h4 && state_ff == IMAP_IDLE;
  logic [31:0] rsel;
  always_comb begin
    unique case (avs_address)
      4'h0: rsel = {16'h0000, addr_ff};
      4'h1: rsel = {28'h000_0000, excl_ff, size_ff};
      4'h2: rsel = wdata_ff[31:0];
      4'h3: rsel = wdata_ff[63:32];
      4'h5: rsel = {30'h0000_0000, err_ff, state_ff != IMAP_IDLE};
      4'h6: rsel = rdata_ff[31:0];
      4'h7: rsel = rdata_ff[63:32];
      default: rsel = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      avs_ack_ff <= 1'b0;
      avs_rd_ff <= 32'h0000_0000;
      addr_ff <= 16'h0000;
      size_ff <= `IMAP_SZ_W;
      excl_ff <= 1'b0;
      wdata_ff <= 64'h0000_0000_0000_0000;
    end else begin
      avs_ack_ff <= avs_req;
      if (avs_req && avs_read) avs_rd_ff <= rsel;
      if (avs_wr && avs_address == 4'h0) addr_ff <= avs_writedata[15:0];
      if (avs_wr && avs_address == 4'h1) begin
        size_ff <= avs_writedata[2:0];
        excl_ff <= avs_writedata[3];
      end
      if (avs_wr && avs_address == 4'h2) wdata_ff[31:0] <= avs_writedata;
      if (avs_wr && avs_address == 4'h3) wdata_ff[63:32] <= avs_writedata;
    end
  end
  // one single-register access outstanding at a time
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_ff <= IMAP_IDLE;
      wr_ff <= 1'b0;
      rdata_ff <= 64'h0000_0000_0000_0000;
      err_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        IMAP_IDLE: if (go) begin
          wr_ff <= avs_writedata[0];
          state_ff <= IMAP_REQ;
        end
        IMAP_REQ: state_ff <= IMAP_WAIT;
        IMAP_WAIT: if (link.ack) begin
          rdata_ff <= link.rdata;
          err_ff <= link.err;
          state_ff <= IMAP_IDLE;
        end
        default: state_ff <= IMAP_IDLE;
      endcase
    end
  end
  assign avs_waitrequest = (avs_read || avs_write) && !avs_ack_ff;
  assign avs_readdata = avs_rd_ff;
  assign link.req = state_ff == IMAP_REQ;
  assign link.wr = wr_ff;
  assign link.addr = addr_ff;
  assign link.size = size_ff;
  assign link.excl = excl_ff;
  assign link.wdata = wdata_ff;
endmodule : imap_hst

// ==== tb/imap_chk.sv ====
// link checker: answer timing and access legality between the two ends
`timescale 1ns/100ps
`include "imap_defines.svh"
module imap_chk (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // link
  input wire logic req,
  input wire logic [15:0] addr,
  input wire logic [2:0] size,
  input wire logic excl,
  input wire logic ack,
  input wire logic err,
  input wire logic [63:0] rdata
);
  // ==========================================================
  // decode of the request
  wire [3:0] fr = addr[15:12];
  wire [11:0] ofs = addr[11:0];
  wire fw = (fr >= `IMAP_FR_DIST) && (fr <= `IMAP_FR_XLAT);
  wire ok = fw && !excl;
  wire in_arr = (ofs >= `IMAP_OFS_PRIO_LO && ofs <= `IMAP_OFS_PRIO_HI)
    || (ofs >= `IMAP_OFS_TGT_LO && ofs <= `IMAP_OFS_TGT_HI)
    || (ofs >= `IMAP_OFS_SGIP_LO && ofs <= `IMAP_OFS_SGIP_HI);
  wire is_msg = (fr == `IMAP_FR_XLAT && ofs == `IMAP_OFS_DOORBELL) || (fr == `IMAP_FR_DIST
    && ofs >= `IMAP_OFS_SETNS && ofs <= `IMAP_OFS_CLRS && ofs[1:0] == 2'h0);
  wire is64 = ofs == `IMAP_OFS_BASE64 || ofs == `IMAP_OFS_FULL64;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  // ==========================================================
  // answer timing
  property p_ans; req |=> ack; endproperty
  a_ans: assert property (p_ans) else $error("request not answered next cycle");
  property p_cause; ack |-> $past(req) ##1 !ack; endproperty
  a_cause: assert property (p_cause) else $error("answer without request");
  property p_errz; ack && err |-> rdata == 64'h0000_0000_0000_0000; endproperty
  a_errz: assert property (p_errz) else $error("refused access returned data");
  // ==========================================================
  // access legality
  property p_byte; req && ok && fr == `IMAP_FR_DIST && size == `IMAP_SZ_B |=> err == !in_arr;
  endproperty
  a_byte: assert property (p_byte) else $error("byte access class wrong");
  property p_wide; req && fw && size > `IMAP_SZ_D |=> ack && err; endproperty
  a_wide: assert property (p_wide) else $error("wide access not refused");
  property p_excl; req && fw && excl |=> err; endproperty
  a_excl: assert property (p_excl) else $error("exclusive access not refused");
  property p_unal; req && ok && size == `IMAP_SZ_W && addr[1:0] != 2'h0 |=> err; endproperty
  a_unal: assert property (p_unal) else $error("unaligned word not refused");
  property p_full; req && ok && size == `IMAP_SZ_W && ofs[11:3] == 9'h007 |=> err; endproperty
  a_full: assert property (p_full) else $error("word to full-width register accepted");
  property p_dw; req && ok && size == `IMAP_SZ_D && is64 |=> !err; endproperty
  a_dw: assert property (p_dw) else $error("doubleword to 64-bit register refused");
  property p_half; req && !excl && size == `IMAP_SZ_H && is_msg |=> !err; endproperty
  a_half: assert property (p_half) else $error("halfword message write refused");
  property p_w1; req && ok && size == `IMAP_SZ_W && ofs[11:3] == 9'h006 && addr[1:0] == 2'h0
    |=> !err; endproperty
  a_w1: assert property (p_w1) else $error("word half of 64-bit register refused");
endmodule : imap_chk

// ==== tb/intc_mmio_access_port_bench.sv ====
// bench: software drives the host end, the device end answers over the link
`timescale 1ns/100ps
`include "imap_defines.svh"
module intc_mmio_access_port_bench;
  typedef struct {string n; logic [31:0] m; logic [31:0] e;} imap_exp_t;
  localparam logic [63:0] ALL = 64'hFFFF_FFFF_FFFF_FFFF;
  logic clk_sys_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic sysreg_enable_bit = 1'b0;
  logic pmr_we = 1'b0;
  logic [7:0] pmr_wd = 8'h00;
  logic [31:0] pend = 32'h0000_0000;
  logic [7:0] pmask;
  logic g0_en;
  logic g1_en;
  logic irq_req;
  logic [9:0] ack_id;
  logic [9:0] deact_id;
  logic forbid;
  logic forbid_seen = 1'b0;
  logic [31:0] rdv;
  logic [63:0] r64;
  logic [31:0] r32;
  logic [7:0] pm;
  logic [15:0] bad_ad [6] = '{16'h3038, 16'h3030, 16'h3030, 16'h3032, 16'h3030, 16'h3030};
  logic [2:0] bad_sz [6] = '{3'h2, 3'h4, 3'h3, 3'h2, 3'h0, 3'h4};
  integer seed = 32'h70d2_bb54;
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  imap_exp_t q[$];
  // ==========================================================
  // the two ends and the checker
  imap_if link_if ();
  imap_dev #(.PRIO_BITS(8), .NUM_IRQ(32)) imap_dev_inst (.clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i), .bus(link_if), .sysreg_enable_bit_i(sysreg_enable_bit), .sysreg_pmr_we_i(pmr_we),
    .sysreg_pmr_wdata_i(pmr_wd), .irq_pending_i(pend), .priority_mask_o(pmask),
    .group0_enable_o(g0_en), .group1_enable_o(g1_en), .irq_req_o(irq_req),
    .last_ack_id_o(ack_id), .last_deact_id_o(deact_id), .forbidden_o(forbid));
  imap_hst imap_hst_inst (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link(link_if));
  imap_chk imap_chk_inst (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .req(link_if.req),
    .addr(link_if.addr), .size(link_if.size), .excl(link_if.excl), .ack(link_if.ack),
    .err(link_if.err), .rdata(link_if.rdata));
  initial begin
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  // ==========================================================
  // tasks
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test
  task automatic cmp(input string n, input logic [31:0] m, e, v);
    total_checks++;
    if ((v & m) !== (e & m)) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e & m, v & m);
    end
  endtask : cmp
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= d;
    do @(posedge clk_sys_i); while (avs_waitrequest !== 1'b0);
    rdv = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : av
  task automatic rd(input logic [3:0] a, input string n, input logic [31:0] m, e);
    imap_exp_t x;
    x = '{n, m, e};
    q.push_back(x);
    av(1'b0, a, 32'h0000_0000);
  endtask : rd
  task automatic acc(input logic w, input logic [15:0] ad, input logic [2:0] sz, input logic ex,
      input logic [63:0] wd, input logic er, input logic [63:0] m, e);
    av(1'b1, 4'h0, {16'h0000, ad});
    av(1'b1, 4'h1, {28'h000_0000, ex, sz});
    av(1'b1, 4'h2, wd[31:0]);
    av(1'b1, 4'h3, wd[63:32]);
    av(1'b1, 4'h4, {31'h0000_0000, w});
    do rd(4'h5, "status", 32'h0000_0000, 32'h0000_0000); while (rdv[0] !== 1'b0);
    rd(4'h5, "link error", 32'h0000_0002, {30'h0000_0000, er, 1'b0});
    rd(4'h6, "read low", m[31:0], e[31:0]);
    rd(4'h7, "read high", m[63:32], e[63:32]);
  endtask : acc
  task automatic wr(input logic [15:0] ad, input logic [2:0] sz, input logic [63:0] wd);
    acc(1'b1, ad, sz, 1'b0, wd, 1'b0, ALL, 64'h0000_0000_0000_0000);
  endtask : wr
  task automatic rdl(input logic [15:0] ad, input logic [2:0] sz, input logic [63:0] m, e);
    acc(1'b0, ad, sz, 1'b0, 64'h0000_0000_0000_0000, 1'b0, m, e);
  endtask : rdl
  // ==========================================================
  // result monitor and hang guard
  always @(posedge clk_sys_i) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && q.size() > 0) begin
      if (q[0].m !== 32'h0000_0000) cmp(q[0].n, q[0].m, q[0].e, avs_readdata);
      void'(q.pop_front());
    end
    if (forbid === 1'b1) forbid_seen = 1'b1;
    cyc++;
    if (cyc > 30000) begin
      err_total++;
      stop_test();
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    r64 = {$random(seed), $random(seed)};
    r32 = $random(seed);
    pm = 8'($random(seed));
    repeat (10) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    rd(4'h9, "unmapped", 32'hFFFF_FFFF, 32'h0000_0000);
    wr(16'h0004, 3'h2, 64'(pm) << 32);
    cmp("mask", 32'h0000_00FF, 32'(pm), 32'(pmask));
    rdl(16'h0004, 3'h2, 64'hFF << 32, 64'(pm) << 32);
    wr(16'h3030, 3'h3, r64);
    rdl(16'h3030, 3'h3, ALL, r64);
    wr(16'h3034, 3'h2, {r32, 32'h0000_0000});
    rdl(16'h3030, 3'h3, ALL, {r32, r64[31:0]});
    rdl(16'h3030, 3'h2, ALL, {32'h0000_0000, r64[31:0]});
    wr(16'h3038, 3'h3, ~r64);
    for (int i = 0; i < 6; i++) begin
      acc(i != 5, bad_ad[i], bad_sz[i], i == 2, r64, 1'b1, ALL, 64'h0);
    end
    rdl(16'h3038, 3'h3, ALL, ~r64);
    rdl(16'h3030, 3'h3, ALL, {r32, r64[31:0]});
    for (int j = 0; j < 2; j++) begin
      for (int i = 0; i < 4; i++) begin
        wr(16'h3400 + 16'(j * 1024 + i), 3'h0, {32'h0000_0000, r32} & (64'hFF << (8 * i)));
      end
      rdl(16'h3400 + 16'(j * 1024), 3'h2, 64'hFFFF_FFFF, {32'h0000_0000, r32});
    end
    wr(16'h5040, 3'h1, 64'h0000_0000_0000_0000);
    for (int i = 0; i < 4; i++) begin
      wr(16'h3044 + 16'(4 * i), 3'h1, 64'h0000_0000_0000_0000);
    end
    wr(16'h0018, 3'h2, ALL);
    rdl(16'h0018, 3'h2, 64'hFFFF_FFFF, {32'h0000_0000, `IMAP_RST_ROID});
    sysreg_enable_bit <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    cmp("mask cleared", 32'h0000_00FF, 32'h0000_0000, 32'(pmask));
    forbid_seen = 1'b0;
    wr(16'h0004, 3'h2, 64'hFF << 32);
    cmp("forbidden", 32'h0000_0001, 32'h0000_0001, 32'(forbid_seen));
    rdl(16'h0004, 3'h2, ALL, 64'h0000_0000_0000_0000);
    pmr_we <= 1'b1;
    pmr_wd <= pm;
    @(posedge clk_sys_i);
    pmr_we <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    cmp("shared mask", 32'h0000_00FF, 32'(pm), 32'(pmask));
    sysreg_enable_bit <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    cmp("mask cleared", 32'h0000_00FF, 32'h0000_0000, 32'(pmask));
    pend <= 32'h0000_0020;
    wr(16'h0000, 3'h2, 64'h0000_0000_0000_0003);
    cmp("group enables", 32'h0000_0003, 32'h0000_0003, {30'h0000_0000, g1_en, g0_en});
    cmp("masked request", 32'h0000_0001, 32'h0000_0000, 32'(irq_req));
    wr(16'h0004, 3'h2, 64'hFF << 32);
    cmp("request", 32'h0000_0001, 32'h0000_0001, 32'(irq_req));
    rdl(16'h000C, 3'h2, 64'h3FF << 32, 64'h005 << 32);
    cmp("acked id", 32'h0000_03FF, 32'h0000_0005, 32'(ack_id));
    cmp("request after ack", 32'h0000_0001, 32'h0000_0000, 32'(irq_req));
    wr(16'h0010, 3'h2, 64'h0000_0000_0000_0005);
    cmp("deactivated id", 32'h0000_03FF, 32'h0000_0005, 32'(deact_id));
    stop_test();
  end
endmodule : intc_mmio_access_port_bench
